// ### design/acpl_pkg.sv
// constants and types shared by the amplifier control-pin logic
package acpl_pkg;
    // number of output power stages, one fault output each
    localparam int NUM_STAGES = 4;
    // operating states that steer the shared pins
    typedef enum logic [1:0] {
        ACPL_RESET,
        ACPL_INIT,
        ACPL_BOOT,
        ACPL_RUN
    } acpl_state_t;
    // stage topology and amplifier mode codes are two bits wide
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_RESET_VAL = 2'h0;
    // bit positions of the mode pair
    localparam int MODE_BIT0 = 0;
    localparam int MODE_BIT1 = 1;
    // bit positions of the topology pair inside the synchronised strap word
    localparam int TOPO_BIT0 = 2;
    localparam int TOPO_BIT1 = 3;
    // synchroniser fill count after release before the mode straps are taken
    localparam logic [1:0] SETTLE_STEP = 2'h1;
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    // encoder phase width
    localparam int ENC_W = 2;
    localparam logic [1:0] ENC_RESET_VAL = 2'h3;
    // volume step counter width and reset value
    localparam int VOL_W = 8;
    localparam logic [7:0] VOL_RESET_VAL = 8'h00;
    localparam logic [7:0] VOL_ONE = 8'h01;
    // calibration timer width and reset value
    localparam int CAL_W = 16;
    localparam logic [15:0] CAL_RESET_VAL = 16'h0000;
    localparam logic [15:0] CAL_ONE = 16'h0001;
endpackage

// ### design/acpl_amp_control_pin_logic.sv
// control-pin logic of the amplifier controller: power-down, faults, straps, shared pins
`timescale 1ns/10ps
module acpl_amp_control_pin_logic
    import acpl_pkg::*;
#(
    parameter int NSTAGE = NUM_STAGES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic init_done, // firmware sequencer: initialization finished
    input wire logic firmware_start, // firmware sequencer: firmware begins running
    input wire logic output_power_down_n, // power-down request, active low
    input wire logic [NSTAGE-1:0] stage_overcurrent, // per-stage monitors
    input wire logic [NSTAGE-1:0] stage_overload,
    input wire logic supply_undervoltage,
    input wire logic [NSTAGE-1:0] firmware_oc_clear,
    input wire logic [NSTAGE-1:0] pwm_drive_in, // pwm drive from the modulator
    input wire logic audio_enable_in,
    input wire logic stage_topology_sel0, // stage topology straps
    input wire logic stage_topology_sel1,
    input wire logic amp_mode_sel0_in, // mode strap, later protect status
    output logic amp_mode_sel0_out,
    output logic amp_mode_sel0_oe,
    input wire logic amp_mode_sel1_in, // mode strap, later supply sync
    output logic amp_mode_sel1_out,
    output logic amp_mode_sel1_oe,
    input wire logic supply_sync_in, // firmware-made sync waveform
    input wire logic protect_status_n_in, // firmware protection status, active low
    output logic [NSTAGE-1:0] stage_fault_n_out, // per-stage fault pins, open-drain
    output logic [NSTAGE-1:0] stage_fault_n_oe,
    input wire logic temp_reference_pin_in, // spi clock / temperature reference pin
    output logic temp_reference_pin_out,
    output logic temp_reference_pin_oe,
    input wire logic thermistor_pin_in, // mosi / thermistor pin
    output logic thermistor_pin_out,
    output logic thermistor_pin_oe,
    input wire logic encoder_phase_b_in, // miso / encoder phase b pin
    output logic encoder_phase_b_out,
    output logic encoder_phase_b_oe,
    input wire logic encoder_phase_a, // slave select / encoder phase a, always an input
    input wire logic spi_clock_in, // internal spi engine side
    input wire logic spi_mosi_in,
    input wire logic spi_miso_in,
    output logic spi_master_in_reg_o,
    input wire logic thermistor_drive, // temperature algorithm side
    input wire logic thermistor_oe_req,
    input wire logic temp_common_pin,
    output logic timer_io0,
    output logic [NSTAGE-1:0] pwm_drive_out, // outputs to the core
    output logic [NSTAGE-1:0] stage_float,
    output logic audio_enable_out,
    output logic [MODE_W-1:0] amp_mode,
    output logic [MODE_W-1:0] stage_topology,
    output logic [NSTAGE-1:0] oc_latched,
    output logic [VOL_W-1:0] volume_count,
    output logic volume_step,
    output logic [CAL_W-1:0] cal_count,
    output logic temp_ref_level,
    output logic thermistor_level,
    output logic [1:0] op_state
);
    import acpl_pkg::*;
    // every assertion below samples on the system clock and rests during reset
    default clocking assert_clk @(posedge clock); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic pdn_s1_reg; // first stage, read only by second stage
    logic pdn_s2_reg; // synchronised power-down level
    logic [3:0] strap_s1_reg; // topology pair and mode pair, first stage
    logic [3:0] strap_s2_reg; // synchronised straps
    wire logic pd_active = !pdn_s2_reg; // power-down asserted, second flop only

    // two flops before any use of power-down and the straps
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pdn_s1_reg <= 1'b1;
            pdn_s2_reg <= 1'b1;
            strap_s1_reg <= 4'h0;
            strap_s2_reg <= 4'h0;
        end else begin
            pdn_s1_reg <= output_power_down_n;
            pdn_s2_reg <= pdn_s1_reg;
            strap_s1_reg <= {stage_topology_sel1, stage_topology_sel0,
                             amp_mode_sel1_in, amp_mode_sel0_in};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // operating state
    // ------------------------------------------------------------
    acpl_state_t state_reg;
    logic latch_pending_reg; // sample straps once the synchroniser has filled
    logic [1:0] settle_reg; // counts synchroniser fill after release

    // reset -> init -> boot -> run; the state, and slave select outside run, decide pin roles
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ACPL_RESET;
        end else begin
            case (state_reg)
                ACPL_RESET: if (!latch_pending_reg) state_reg <= ACPL_INIT;
                ACPL_INIT: if (init_done) state_reg <= ACPL_BOOT;
                ACPL_BOOT: if (firmware_start) state_reg <= ACPL_RUN;
                default: state_reg <= ACPL_RUN; // run holds until reset
            endcase
        end
    end

    // ------------------------------------------------------------
    // strap latching
    // ------------------------------------------------------------
    // wait two edges so the synchroniser holds the pin levels, not reset values
    always_ff @(posedge clock) begin
        if (!nrst) begin
            settle_reg <= 2'h0;
            latch_pending_reg <= 1'b1;
        end else if (latch_pending_reg) begin
            settle_reg <= settle_reg + SETTLE_STEP;
            if (settle_reg == SETTLE_LAST) latch_pending_reg <= 1'b0;
        end
    end

    // mode pair latched once after release and held; topology follows the pins
    always_ff @(posedge clock) begin
        if (!nrst) begin
            amp_mode <= MODE_RESET_VAL;
            stage_topology <= MODE_RESET_VAL;
        end else begin
            if (latch_pending_reg && settle_reg == SETTLE_LAST) begin
                amp_mode <= strap_s2_reg[MODE_BIT1:MODE_BIT0];
            end
            stage_topology <= strap_s2_reg[TOPO_BIT1:TOPO_BIT0]; // static, not latched
        end
    end

    // ------------------------------------------------------------
    // per-stage protection and faults
    // ------------------------------------------------------------
    // fixed hardware roles: nothing here is writable by software
    generate
        for (genvar g = 0; g < NSTAGE; g++) begin : g_stage
            // overcurrent latch: set wins over firmware clear; power-down clears
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    oc_latched[g] <= 1'b0;
                end else if (pd_active) begin
                    oc_latched[g] <= 1'b0;
                end else if (stage_overcurrent[g]) begin
                    oc_latched[g] <= 1'b1;
                end else if (firmware_oc_clear[g]) begin
                    oc_latched[g] <= 1'b0;
                end
            end
            // fault pulls low only; otherwise released, never driven high
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    stage_fault_n_out[g] <= 1'b0;
                    stage_fault_n_oe[g] <= 1'b0;
                end else begin
                    stage_fault_n_out[g] <= 1'b0;
                    stage_fault_n_oe[g] <= pd_active || supply_undervoltage
                        || stage_overcurrent[g] || stage_overload[g]
                        || oc_latched[g];
                end
            end
            // stage drive removed and floated on power-down or latched shutdown
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    pwm_drive_out[g] <= 1'b0;
                    stage_float[g] <= 1'b1;
                end else begin
                    pwm_drive_out[g] <= pwm_drive_in[g] && !pd_active && !oc_latched[g];
                    stage_float[g] <= pd_active || oc_latched[g];
                end
            end
        end
    endgenerate

    // audio outputs muted during power-down; the rest of the logic keeps running
    always_ff @(posedge clock) begin
        if (!nrst) begin
            audio_enable_out <= 1'b0;
        end else begin
            audio_enable_out <= audio_enable_in && !pd_active;
        end
    end

    // ------------------------------------------------------------
    // shared mode pins: straps until firmware runs, then outputs
    // ------------------------------------------------------------
    // reset and every pre-run state leave both pins released as strap inputs
    always_ff @(posedge clock) begin
        if (nrst && state_reg == ACPL_RUN) begin
            // protect status is open-drain style: pull low when asserted
            amp_mode_sel0_out <= 1'b0;
            amp_mode_sel0_oe <= !protect_status_n_in;
            amp_mode_sel1_out <= supply_sync_in;
            amp_mode_sel1_oe <= 1'b1;
        end else begin
            amp_mode_sel0_out <= 1'b0;
            amp_mode_sel0_oe <= 1'b0;
            amp_mode_sel1_out <= 1'b0;
            amp_mode_sel1_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // spi / temperature / encoder pins
    // ------------------------------------------------------------
    wire logic spi_phase = (state_reg != ACPL_RUN); // spi roles held outside run
    wire logic spi_master = encoder_phase_a; // slave select high: master-side directions

    // pin directions steered by state and, in every state but run, by slave select
    always_ff @(posedge clock) begin
        if (!nrst) begin
            temp_reference_pin_out <= 1'b0;
            temp_reference_pin_oe <= 1'b0;
            thermistor_pin_out <= 1'b0;
            thermistor_pin_oe <= 1'b0;
            encoder_phase_b_out <= 1'b0;
            encoder_phase_b_oe <= 1'b0;
            spi_master_in_reg_o <= 1'b0;
        end else if (spi_phase) begin
            temp_reference_pin_out <= spi_clock_in;
            temp_reference_pin_oe <= 1'b1;
            thermistor_pin_out <= spi_mosi_in;
            thermistor_pin_oe <= spi_master;
            encoder_phase_b_out <= spi_miso_in;
            encoder_phase_b_oe <= !spi_master;
            spi_master_in_reg_o <= spi_master ? encoder_phase_b_in : thermistor_pin_in;
        end else begin
            temp_reference_pin_out <= 1'b0;
            temp_reference_pin_oe <= 1'b0; // reference is input
            thermistor_pin_out <= thermistor_drive;
            thermistor_pin_oe <= thermistor_oe_req;
            encoder_phase_b_out <= 1'b0;
            encoder_phase_b_oe <= 1'b0;
            spi_master_in_reg_o <= 1'b0;
        end
    end

    // temperature pin levels sampled for the measurement sequence
    always_ff @(posedge clock) begin
        if (!nrst) begin
            temp_ref_level <= 1'b0;
            thermistor_level <= 1'b0;
        end else if (!spi_phase) begin
            temp_ref_level <= temp_reference_pin_in;
            thermistor_level <= thermistor_pin_in;
        end
    end

    // timer: counts system clocks while the common pin is high, snapshot on fall
    logic [CAL_W-1:0] cal_run_reg;
    logic com_prev_reg;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cal_run_reg <= CAL_RESET_VAL;
            cal_count <= CAL_RESET_VAL;
            com_prev_reg <= 1'b0;
            timer_io0 <= 1'b0;
        end else begin
            com_prev_reg <= temp_common_pin;
            timer_io0 <= temp_common_pin && !spi_phase;
            if (spi_phase) begin
                cal_run_reg <= CAL_RESET_VAL;
            end else if (temp_common_pin) begin
                cal_run_reg <= cal_run_reg + CAL_ONE;
            end else if (com_prev_reg) begin
                cal_count <= cal_run_reg;
                cal_run_reg <= CAL_RESET_VAL;
            end
        end
    end

    // quadrature decode; edge on phase a sets direction from phase b
    logic [ENC_W-1:0] enc_prev_reg;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            enc_prev_reg <= ENC_RESET_VAL;
            volume_count <= VOL_RESET_VAL;
            volume_step <= 1'b0;
        end else begin
            enc_prev_reg <= {encoder_phase_b_in, encoder_phase_a};
            volume_step <= 1'b0;
            if (!spi_phase && (encoder_phase_a != enc_prev_reg[0])) begin
                volume_step <= 1'b1;
                volume_count <= (encoder_phase_a ^ encoder_phase_b_in) ?
                    volume_count + VOL_ONE : volume_count - VOL_ONE;
            end
        end
    end

    // state code out for the core
    always_ff @(posedge clock) begin
        if (!nrst) op_state <= 2'h0;
        else op_state <= state_reg;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pd_faults;
        pd_active |=> (&stage_fault_n_oe);
    endproperty
    a_pd_faults: assert property (p_pd_faults) else $error("faults not low in power-down");
    property p_uv_faults;
        supply_undervoltage |=> (&stage_fault_n_oe);
    endproperty
    a_uv_faults: assert property (p_uv_faults) else $error("undervoltage faults missing");
    property p_od;
        stage_fault_n_out == '0;
    endproperty
    a_od: assert property (p_od) else $error("fault pin driven high");
    property p_pd_float;
        pd_active |=> (&stage_float) && (pwm_drive_out == '0) && !audio_enable_out;
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("stage drive during power-down");
    property p_pd_clear;
        pd_active |=> (oc_latched == '0);
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("latch kept in power-down");
    property p_ovl;
        (stage_overload != '0) |=>
            ((stage_fault_n_oe & $past(stage_overload)) == $past(stage_overload));
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload fault missing");
    property p_mode_hold;
        !latch_pending_reg |=> $stable(amp_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed after latch");
    property p_run_roles;
        (state_reg == ACPL_RUN) ##1 (state_reg == ACPL_RUN) |->
            amp_mode_sel1_oe && !temp_reference_pin_oe && !encoder_phase_b_oe;
    endproperty
    a_run_roles: assert property (p_run_roles) else $error("run pin roles wrong");
    property p_pdn_sync;
        $fell(output_power_down_n) ##1 !output_power_down_n |=> pd_active;
    endproperty
    a_pdn_sync: assert property (p_pdn_sync) else $error("power-down sync latency");
endmodule

// ### verif/acpl_board_model.sv
// board-side model: strap resistors, fault wire-or, protect net
`timescale 1ns/10ps
module acpl_board_model (
    input wire logic [1:0] strap_mode,
    input wire logic sel0_out,
    input wire logic sel0_oe,
    input wire logic sel1_out,
    input wire logic sel1_oe,
    input wire logic [3:0] fault_out,
    input wire logic [3:0] fault_oe,
    output logic sel0_wire,
    output logic sel1_wire,
    output logic [3:0] fault_wire,
    output logic [1:0] protect_wire
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // the strap value feeds only the mode pair; the topology pair is driven by the bench
    // undriven mode pins fall back to their strap resistor
    assign sel0_wire = sel0_oe ? sel0_out : strap_mode[0];
    assign sel1_wire = sel1_oe ? sel1_out : strap_mode[1];
    // pull-ups on every fault net; a driver only pulls low
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            fault_wire[i] = (fault_oe[i] && (fault_out[i] === 1'b0)) ? 1'b0 : 1'b1;
        end
    end
    // paired stages share one protect net per channel
    assign protect_wire = {fault_wire[3] & fault_wire[2], fault_wire[1] & fault_wire[0]};
endmodule

// ### verif/testbench.sv
// self-checking bench for the amplifier control-pin logic
`timescale 1ns/10ps
module testbench;
    import acpl_pkg::*;
    logic clock = 0, nrst = 0, init_done = 0, firmware_start = 0, pd_n = 1, uv = 0;
    logic [3:0] oc = 0, ol = 0, oc_clr = 0, pwm_in = 4'hF, f_out, f_oe, f_wire, pwm_out, flt;
    logic aud_in = 1, topo0 = 1, topo1 = 1, sync_in = 0, prot_n = 1, s0o, s0e, s1o, s1e;
    logic s0w, s1w, ref_in = 0, ref_o, ref_e, th_in = 0, th_o, th_e, b_in = 1, b_o, b_e;
    logic enc_a = 1, sck = 0, mosi = 0, miso = 0, mi_reg, th_drv = 0, th_req = 0, tcom = 0;
    logic tio, aud_out, vstep, tref_l, th_l;
    logic [1:0] strap = 2'h3, amp_mode, topo, op_state, prot_w;
    logic [3:0] oc_lat;
    logic [7:0] vol;
    logic [15:0] cal;
    int errors = 0, tests_run = 0, cycles = 0;
    // ------------------------------------------------------------
    // clock, timeout, instances
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clock = ~clock;
    end
    // the whole run takes well under 1000 cycles; 5000 means a hang
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            summarize();
        end
    end
    acpl_board_model board (.strap_mode(strap), .sel0_out(s0o), .sel0_oe(s0e),
        .sel1_out(s1o), .sel1_oe(s1e), .fault_out(f_out), .fault_oe(f_oe),
        .sel0_wire(s0w), .sel1_wire(s1w), .fault_wire(f_wire), .protect_wire(prot_w));
    acpl_amp_control_pin_logic DUT (.clock(clock), .nrst(nrst), .init_done(init_done),
        .firmware_start(firmware_start), .output_power_down_n(pd_n),
        .stage_overcurrent(oc), .stage_overload(ol), .supply_undervoltage(uv),
        .firmware_oc_clear(oc_clr), .pwm_drive_in(pwm_in), .audio_enable_in(aud_in),
        .stage_topology_sel0(topo0), .stage_topology_sel1(topo1),
        .amp_mode_sel0_in(s0w), .amp_mode_sel0_out(s0o), .amp_mode_sel0_oe(s0e),
        .amp_mode_sel1_in(s1w), .amp_mode_sel1_out(s1o), .amp_mode_sel1_oe(s1e),
        .supply_sync_in(sync_in), .protect_status_n_in(prot_n),
        .stage_fault_n_out(f_out), .stage_fault_n_oe(f_oe),
        .temp_reference_pin_in(ref_in), .temp_reference_pin_out(ref_o),
        .temp_reference_pin_oe(ref_e), .thermistor_pin_in(th_in),
        .thermistor_pin_out(th_o), .thermistor_pin_oe(th_e),
        .encoder_phase_b_in(b_in), .encoder_phase_b_out(b_o), .encoder_phase_b_oe(b_e),
        .encoder_phase_a(enc_a), .spi_clock_in(sck), .spi_mosi_in(mosi),
        .spi_miso_in(miso), .spi_master_in_reg_o(mi_reg), .thermistor_drive(th_drv),
        .thermistor_oe_req(th_req), .temp_common_pin(tcom), .timer_io0(tio),
        .pwm_drive_out(pwm_out), .stage_float(flt), .audio_enable_out(aud_out),
        .amp_mode(amp_mode), .stage_topology(topo), .oc_latched(oc_lat),
        .volume_count(vol), .volume_step(vstep), .cal_count(cal),
        .temp_ref_level(tref_l), .thermistor_level(th_l), .op_state(op_state));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // wait n falling edges; inputs change and outputs are read there
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reset for six cycles with the given strap mode on both pairs
    task automatic do_reset(input logic [1:0] mode);
        nrst = 0;
        strap = mode;
        {topo1, topo0} = mode;
        wait_n(6);
        check(flt, 4'hF);
        check(f_oe, 4'h0);
        nrst = 1;
        wait_n(6);
    endtask
    task automatic summarize();
        $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(2'h3);
        check(amp_mode, 2'h3);
        check(op_state, ACPL_INIT);
        check({s0e, s1e}, 2'h0);
        strap = 2'h1;
        {topo1, topo0} = 2'h1;
        wait_n(5);
        check(amp_mode, 2'h3);
        check(topo, 2'h1);
        strap = 2'h3;
        {topo1, topo0} = 2'h3;
        $display("test straps done");
        // spi roles during init: slave select high means master
        sck = 1;
        mosi = 1;
        b_in = 0;
        th_in = 1;
        wait_n(4);
        check({ref_e, ref_o, th_e, th_o, b_e}, 5'h1E);
        check(mi_reg, 1'b0);
        enc_a = 0;
        miso = 1;
        wait_n(4);
        check({th_e, b_e, b_o}, 3'h3);
        check(mi_reg, 1'b1);
        enc_a = 1;
        b_in = 1;
        $display("test spi done");
        // state walk: firmware_start ignored in init
        firmware_start = 1;
        wait_n(1);
        firmware_start = 0;
        wait_n(3);
        check(op_state, ACPL_INIT);
        init_done = 1;
        wait_n(1);
        init_done = 0;
        wait_n(3);
        check(op_state, ACPL_BOOT);
        firmware_start = 1;
        wait_n(1);
        firmware_start = 0;
        wait_n(3);
        check(op_state, ACPL_RUN);
        sync_in = 1;
        wait_n(3);
        check({s1e, s1w, s0w}, 3'h7);
        sync_in = 0;
        prot_n = 0;
        wait_n(3);
        check({s1w, s0w}, 2'h0);
        prot_n = 1;
        check({pwm_out, aud_out, flt}, 9'h1F0);
        $display("test states done");
        // faults: per stage latch, firmware clear, overload, undervoltage
        oc[1] = 1;
        wait_n(2);
        oc[1] = 0;
        wait_n(4);
        check(oc_lat, 4'h2);
        check(f_wire, 4'hD);
        check(prot_w, 2'h2);
        oc_clr[1] = 1;
        wait_n(2);
        oc_clr[1] = 0;
        wait_n(4);
        check({oc_lat, f_wire}, 8'h0F);
        oc[0] = 1;
        oc_clr[0] = 1;
        wait_n(3);
        check(oc_lat, 4'h1);
        oc[0] = 0;
        wait_n(3);
        check(oc_lat, 4'h0);
        oc_clr[0] = 0;
        ol[2] = 1;
        wait_n(4);
        check(f_wire, 4'hB);
        ol[2] = 0;
        uv = 1;
        wait_n(4);
        check(f_wire, 4'h0);
        uv = 0;
        oc[3] = 1;
        wait_n(2);
        oc[3] = 0;
        wait_n(4);
        check(oc_lat, 4'h8);
        // power-down floats stages and pulls every fault low
        pd_n = 0;
        wait_n(4);
        check({pwm_out, aud_out, flt}, 9'h00F);
        check({f_oe, f_out, f_wire}, 12'hF00);
        check(op_state, ACPL_RUN);
        pd_n = 1;
        wait_n(5);
        check({oc_lat, f_wire, pwm_out}, 12'h0FF);
        $display("test faults done");
        // encoder: two opposite phase a edges cancel
        enc_a = 0;
        wait_n(1);
        check(vstep, 1'b1);
        wait_n(4);
        check(vol, VOL_ONE);
        check(vstep, 1'b0);
        enc_a = 1;
        wait_n(5);
        check(vol, VOL_RESET_VAL);
        // temperature pins and clock calibration
        th_req = 1;
        th_drv = 1;
        ref_in = 1;
        th_in = 0;
        wait_n(4);
        check({th_e, th_o, ref_e, tref_l}, 4'hD);
        check(th_l, 1'b0);
        th_req = 0;
        tcom = 1;
        wait_n(20);
        check(tio, 1'b1);
        tcom = 0;
        wait_n(4);
        check(cal, 16'h0014);
        $display("test run pins done");
        // second reset picks up a new strap mode
        do_reset(2'h2);
        check(amp_mode, 2'h2);
        $display("test second reset done");
        summarize();
    end
endmodule
